// ==== include/tap_params.svh ====
// widths, instruction codes, id fields and chain positions of the scan port
`ifndef TAP_PARAMS_SVH
`define TAP_PARAMS_SVH
`define IR_WIDTH 3
`define ID_WIDTH 32
`define BSR_LONG 70
`define BSR_SHORT 51
`define INS_EXTEST 3'h0
`define INS_IDCODE 3'h1
`define INS_SAMPLE_Z 3'h2
`define INS_SAMPLE 3'h4
`define INS_BYPASS 3'h7
`define IR_CAPTURE 3'h1
`define ID_DEPTH_LO 23
`define ID_WIDTH_LO 18
`define ID_MAKER_LO 1
`define ID_PRESENT_BIT 0
`define LONG_ADDR_LAST 7
`define LONG_LANE_FIRST 8
`define LONG_LANE_LAST 16
`define LONG_SLEEP_POS 17
`define LONG_A1_POS 69
`define LONG_A0_POS 70
`define SHORT_SLEEP_POS 12
`define SHORT_CLK_POS 27
`define SHORT_A1_POS 50
`define SHORT_A0_POS 51
`endif

// ==== include/tap_pkg.sv ====
// types of the scan port
package tap_pkg;
    typedef enum logic [15:0] {
        TLR = 16'h0001, RTI = 16'h0002, SEL_DR = 16'h0004, CAP_DR = 16'h0008,
        SH_DR = 16'h0010, EX1_DR = 16'h0020, PA_DR = 16'h0040, EX2_DR = 16'h0080,
        UPD_DR = 16'h0100, SEL_IR = 16'h0200, CAP_IR = 16'h0400, SH_IR = 16'h0800,
        EX1_IR = 16'h1000, PA_IR = 16'h2000, EX2_IR = 16'h4000, UPD_IR = 16'h8000
    } tap_state_t;
endpackage : tap_pkg

// ==== rtl/tap_sync.sv ====
// two-stage synchroniser for a group of pin inputs
`timescale 1ns/1ps
module tap_sync #(
    parameter int W = 1
) (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_q;
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            meta_q <= '0;
            q <= '0;
        end else begin
            meta_q <= d;
            q <= meta_q;
        end
    end
endmodule : tap_sync

// ==== rtl/sram_jtag_tap.sv ====
// boundary-scan test access port of the burst memory, sampled on mclk
// Functional notes
// - instruction 3 bits, bypass 1, identification 32, boundary chain 70 or 51.
// - code 000 captures pins into boundary chain and floats memory outputs.
// - code 001 captures identification value into the scanned register.
// - code 010 captures pins into boundary chain and floats memory outputs.
// - code 100 captures pins into boundary chain, memory unaffected.
// - code 111 selects the single bypass bit.
// - long chain: address 1-7, first lane 8-16, sleep 17, low burst bits 69-70.
// - short chain: sleep at 12, memory clock 27, low burst bits 50 and 51.
// - identification instruction loaded at reset and in test-logic-reset.
// - update state of data path does nothing; no preload exists.
// - id value: depth 27:23, width 22:18, bit 0 one.
`timescale 1ns/1ps
`include "tap_params.svh"
module sram_jtag_tap import tap_pkg::*; #(
    parameter bit WIDE = 1'b0,
    parameter logic [3:0] REVISION = 4'h0,
    parameter logic [4:0] DEPTH_CODE = 5'h07,
    parameter logic [4:0] WIDTH_CODE = 5'h04,
    parameter logic [5:0] DEVICE_CODE = 6'h00,
    // arbitrary neutral maker code
    parameter logic [10:0] MAKER_CODE = 11'h155
) (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic test_clk,
    input wire logic test_mode_sel,
    input wire logic test_data_in,
    output logic test_data_out,
    output logic test_data_out_en,
    output logic mem_output_float,
    input wire logic [6:0] address_input,
    input wire logic [7:0] first_data_lane,
    input wire logic sleep_input,
    input wire logic mem_clk,
    input wire logic burst_address_second_bit,
    input wire logic burst_address_low_bit,
    input wire logic [`BSR_LONG-1:0] other_pins
);
    localparam int BSR_LEN = WIDE ? `BSR_SHORT : `BSR_LONG;
    logic [2:0] pins_s;
    logic [`BSR_LONG-1:0] ring_s;
    logic [`BSR_LONG-1:0] ring_raw;
    logic tck_q;
    logic rise;
    logic fall;
    tap_state_t state_q;
    tap_state_t state_d;
    logic [`IR_WIDTH-1:0] ir_q;
    logic [`IR_WIDTH-1:0] ir_sh_q;
    logic bypass_q;
    logic [`ID_WIDTH-1:0] id_q;
    logic [`BSR_LONG-1:0] bsr_q;
    logic [`ID_WIDTH-1:0] id_value;
    logic serial_bit;

    tap_sync #(.W(3)) u_sync_ctl (
        .mclk(mclk), .resetn(resetn),
        .d({test_clk, test_mode_sel, test_data_in}), .q(pins_s)
    );
    // a pin that moves near a capture may be read either way; only settled pins are reliable
    tap_sync #(.W(`BSR_LONG)) u_sync_ring (
        .mclk(mclk), .resetn(resetn), .d(ring_raw), .q(ring_s)
    );

    // chain position n sits at bit n-1
    always_comb begin
        ring_raw = other_pins;
        if (WIDE) begin
            ring_raw[`SHORT_SLEEP_POS-1] = sleep_input;
            ring_raw[`SHORT_CLK_POS-1] = mem_clk;
            ring_raw[`SHORT_A1_POS-1] = burst_address_second_bit;
            ring_raw[`SHORT_A0_POS-1] = burst_address_low_bit;
            ring_raw[`BSR_LONG-1:`BSR_SHORT] = '0;
        end else begin
            ring_raw[`LONG_ADDR_LAST-1:0] = address_input;
            // the ninth position of the lane is not a port and keeps its ring value
            ring_raw[`LONG_LANE_LAST-1:`LONG_LANE_FIRST-1] =
                {other_pins[`LONG_LANE_LAST-1], first_data_lane};
            ring_raw[`LONG_SLEEP_POS-1] = sleep_input;
            ring_raw[`LONG_A1_POS-1] = burst_address_second_bit;
            ring_raw[`LONG_A0_POS-1] = burst_address_low_bit;
        end
    end

    assign id_value = {REVISION, DEPTH_CODE, WIDTH_CODE, DEVICE_CODE, MAKER_CODE,
        1'b1};

    function automatic logic is_chain(input logic [2:0] ins);
        is_chain = (ins == `INS_EXTEST) || (ins == `INS_SAMPLE_Z) || (ins == `INS_SAMPLE);
    endfunction : is_chain

    // edges are found on the synchronised copy, so each one is seen about three mclk late
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            tck_q <= 1'b0;
        end else begin
            tck_q <= pins_s[2];
        end
    end
    assign rise = pins_s[2] & ~tck_q;
    assign fall = ~pins_s[2] & tck_q;

    always_comb begin
        case (state_q)
            TLR: state_d = pins_s[1] ? TLR : RTI;
            RTI: state_d = pins_s[1] ? SEL_DR : RTI;
            SEL_DR: state_d = pins_s[1] ? SEL_IR : CAP_DR;
            CAP_DR: state_d = pins_s[1] ? EX1_DR : SH_DR;
            SH_DR: state_d = pins_s[1] ? EX1_DR : SH_DR;
            EX1_DR: state_d = pins_s[1] ? UPD_DR : PA_DR;
            PA_DR: state_d = pins_s[1] ? EX2_DR : PA_DR;
            EX2_DR: state_d = pins_s[1] ? UPD_DR : SH_DR;
            UPD_DR: state_d = pins_s[1] ? SEL_DR : RTI;
            SEL_IR: state_d = pins_s[1] ? TLR : CAP_IR;
            CAP_IR: state_d = pins_s[1] ? EX1_IR : SH_IR;
            SH_IR: state_d = pins_s[1] ? EX1_IR : SH_IR;
            EX1_IR: state_d = pins_s[1] ? UPD_IR : PA_IR;
            PA_IR: state_d = pins_s[1] ? EX2_IR : PA_IR;
            EX2_IR: state_d = pins_s[1] ? UPD_IR : SH_IR;
            UPD_IR: state_d = pins_s[1] ? SEL_DR : RTI;
            default: state_d = TLR;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            state_q <= TLR;
        end else if (rise) begin
            state_q <= state_d;
        end
    end

    // the instruction is forced on the rise that enters test-logic-reset, so the memory
    // outputs stop floating while the controller still sits in that state
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            ir_q <= `INS_IDCODE;
        end else if (rise) begin
            if (state_d == TLR) begin
                ir_q <= `INS_IDCODE;
            end else if (state_q == UPD_IR) begin
                ir_q <= ir_sh_q;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            ir_sh_q <= '0;
        end else if (rise) begin
            if (state_q == CAP_IR) begin
                ir_sh_q <= `IR_CAPTURE;
            end else if (state_q == SH_IR) begin
                ir_sh_q <= {pins_s[0], ir_sh_q[`IR_WIDTH-1:1]};
            end
        end
    end

    // update of the data path is left out on purpose: no preload
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            bypass_q <= 1'b0;
            id_q <= '0;
            bsr_q <= '0;
        end else if (rise) begin
            if (state_q == CAP_DR) begin
                bypass_q <= 1'b0;
                if (ir_q == `INS_IDCODE) begin
                    id_q <= id_value;
                end
                if (is_chain(ir_q)) begin
                    bsr_q <= ring_s;
                end
            end else if (state_q == SH_DR) begin
                bypass_q <= pins_s[0];
                if (ir_q == `INS_IDCODE) begin
                    id_q <= {pins_s[0], id_q[`ID_WIDTH-1:1]};
                end
                if (is_chain(ir_q)) begin
                    bsr_q <= {pins_s[0], bsr_q[`BSR_LONG-1:1]};
                    bsr_q[BSR_LEN-1] <= pins_s[0];
                end
            end
        end
    end

    // reserved codes fall back to bypass so the chain stays one bit long
    always_comb begin
        if (state_q == SH_IR) begin
            serial_bit = ir_sh_q[0];
        end else if (ir_q == `INS_IDCODE) begin
            serial_bit = id_q[0];
        end else if (is_chain(ir_q)) begin
            serial_bit = bsr_q[0];
        end else begin
            serial_bit = bypass_q;
        end
    end

    // data-out moves on the fall so that the controller samples a settled bit at the next rise
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            test_data_out <= 1'b0;
            test_data_out_en <= 1'b0;
        end else if (fall) begin
            test_data_out <= serial_bit;
            test_data_out_en <= (state_q == SH_DR) || (state_q == SH_IR);
        end
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            mem_output_float <= 1'b0;
        end else begin
            mem_output_float <= (ir_q == `INS_EXTEST) ||
                (ir_q == `INS_SAMPLE_Z);
        end
    end
endmodule : sram_jtag_tap

// ==== tb/scan_master.sv ====
// behavioural model of the external scan controller driving the test pins
`timescale 1ns/1ps
module scan_master (
    output logic test_clk,
    output logic test_mode_sel,
    output logic test_data_in,
    input wire logic test_data_out
);
    logic [69:0] got;
    bit got_tgl;
    initial begin
        test_clk = 1'b0;
        test_mode_sel = 1'b1;
        test_data_in = 1'b0;
        got = '0;
    end
    // one 125 ns test clock; the clock rests low between calls, so it stands still outside frames
    task automatic step(input logic tms, input logic tdi, output logic tdo);
        test_mode_sel <= tms;
        test_data_in <= tdi;
        #62.5;
        tdo = test_data_out;
        test_clk <= 1'b1;
        #62.5;
        test_clk <= 1'b0;
    endtask : step
    task automatic reset_tap();
        logic tdo;
        repeat (5) step(1'b1, 1'b0, tdo);
        step(1'b0, 1'b0, tdo);
    endtask : reset_tap
    // starts and ends in run-test-idle; data-in shows the inverse once its hold has run out
    task automatic scan(input bit ir, input int n, input logic [69:0] din);
        logic tdo;
        step(1'b1, 1'b0, tdo);
        if (ir) step(1'b1, 1'b0, tdo);
        step(1'b0, 1'b0, tdo);
        step(1'b0, 1'b0, tdo);
        got = '0;
        for (int i = 0; i < n; i++) step(i == n - 1, din[i], got[i]);
        step(1'b1, ~din[n-1], tdo);
        step(1'b0, ~din[n-1], tdo);
        got_tgl = ~got_tgl;
    endtask : scan
endmodule : scan_master

// ==== tb/sram_jtag_tap_props.sv ====
// concurrent checks on the pins of the scan port
`timescale 1ns/1ps
module sram_jtag_tap_props (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic test_clk,
    input wire logic test_mode_sel,
    input wire logic test_data_out,
    input wire logic test_data_out_en,
    input wire logic mem_output_float
);
    logic clk_q;
    logic tms_q;
    logic [2:0] ones_q;
    default clocking @(posedge mclk); endclocking
    default disable iff (!resetn);
    // raw pin edges; the port itself sees them a few cycles later through its synchroniser
    always_ff @(posedge mclk) begin
        clk_q <= test_clk;
    end
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            tms_q <= 1'b1;
            ones_q <= 3'h0;
        end else if (test_clk && !clk_q) begin
            tms_q <= test_mode_sel;
            ones_q <= !test_mode_sel ? 3'h0 : (ones_q == 3'h5 ? ones_q : ones_q + 3'h1);
        end
    end
    sequence high_run_s; test_clk [*4]; endsequence
    sequence shift_exit_s; $fell(test_data_out_en); endsequence
    tdo_fall_only_a: assert property ($changed(test_data_out) |->
        !$past(test_clk, 2) && !$past(test_clk, 3)) else $error("data-out moved off a fall");
    tdo_hold_a: assert property (high_run_s |-> $stable(test_data_out))
        else $error("data-out changed while test clock high");
    en_fall_only_a: assert property ($changed(test_data_out_en) |->
        !$past(test_clk, 2) && !$past(test_clk, 3)) else $error("enable moved off a fall");
    en_rise_a: assert property ($rose(test_data_out_en) |-> !tms_q)
        else $error("shift entered with mode select high");
    shift_exit_a: assert property (shift_exit_s |-> tms_q)
        else $error("shift left with mode select low");
    float_quiet_a: assert property ($changed(mem_output_float) |->
        !test_data_out_en) else $error("float changed during a shift");
    reset_idle_a: assert property ($rose(resetn) |->
        !mem_output_float && !test_data_out_en) else $error("outputs active after reset");
    tlr_id_a: assert property (ones_q == 3'h5 |-> ##8 !mem_output_float)
        else $error("outputs still floated after logic reset");
endmodule : sram_jtag_tap_props
bind sram_jtag_tap sram_jtag_tap_props sram_jtag_tap_props_i (.mclk, .resetn, .test_clk,
    .test_mode_sel, .test_data_out, .test_data_out_en, .mem_output_float);

// ==== tb/test_sram_jtag_tap.sv ====
// self-checking bench of the scan port, long chain variant
`timescale 1ns/1ps
`include "tap_params.svh"
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin errors++; \
    $display("unexpected at %0t got %h exp %h", $time, (g), (e)); end end
module test_sram_jtag_tap;
    logic mclk, resetn, test_clk, test_mode_sel, test_data_in, test_data_out;
    logic test_data_out_en, mem_output_float, sleep_input, mem_clk;
    logic burst_address_second_bit, burst_address_low_bit, float_exp;
    logic [6:0] address_input;
    logic [7:0] first_data_lane;
    logic [69:0] other_pins, din, exp_v;
    logic [69:0] exp_q[$];
    // reserved codes are never sent
    logic [2:0] codes[5] = '{`INS_IDCODE, `INS_SAMPLE, `INS_BYPASS, `INS_SAMPLE_Z, `INS_EXTEST};
    int errors, cmp_count, len;
    integer seed;
    localparam logic [69:0] ID_EXP = {38'h0, 4'h0, 5'h0a, 5'h03, 6'h00, 11'h2a5, 1'b1};
    // maker code 11'h2a5 is arbitrary
    sram_jtag_tap #(.WIDE(1'b0), .DEPTH_CODE(5'h0a), .WIDTH_CODE(5'h03), .MAKER_CODE(11'h2a5))
    sram_jtag_tap_i (.mclk, .resetn, .test_clk, .test_mode_sel, .test_data_in, .test_data_out,
        .test_data_out_en, .mem_output_float, .address_input, .first_data_lane, .sleep_input,
        .mem_clk, .burst_address_second_bit, .burst_address_low_bit, .other_pins);
    scan_master scan_master_i (.test_clk, .test_mode_sel, .test_data_in, .test_data_out);
    always #5 mclk = ~mclk;
    function automatic logic [69:0] ring();
        logic [69:0] e;
        e = other_pins;
        e[6:0] = address_input;
        e[14:7] = first_data_lane;
        e[16] = sleep_input;
        e[68] = burst_address_second_bit;
        e[69] = burst_address_low_bit;
        return e;
    endfunction : ring
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : summarize
    always @(scan_master_i.got_tgl) begin
        exp_v = exp_q.pop_front();
        `CHK(scan_master_i.got, exp_v)
    end
    initial begin
        #200us;
        errors++;
        summarize();
    end
    initial begin
        mclk = 1'b0;
        resetn = 1'b0;
        seed = 32'hf4c4;
        {address_input, first_data_lane, other_pins, din} = '0;
        {sleep_input, mem_clk, burst_address_second_bit, burst_address_low_bit} = 4'h0;
        repeat (4) @(posedge mclk);
        resetn <= 1'b1;
        repeat (4) @(posedge mclk);
        scan_master_i.reset_tap();
        exp_q.push_back(ID_EXP);
        scan_master_i.scan(1'b0, `ID_WIDTH, din);
        $display("test of identification after reset done");
        foreach (codes[k]) begin
            @(posedge mclk);
            address_input <= 7'($random(seed));
            first_data_lane <= 8'($random(seed));
            {sleep_input, mem_clk} <= 2'($random(seed));
            {burst_address_second_bit, burst_address_low_bit} <= 2'($random(seed));
            other_pins <= 70'({$random(seed), $random(seed), $random(seed)});
            din = 70'({$random(seed), $random(seed), $random(seed)});
            exp_q.push_back(70'(`IR_CAPTURE));
            scan_master_i.scan(1'b1, `IR_WIDTH, 70'(codes[k]));
            float_exp = codes[k] == `INS_EXTEST || codes[k] == `INS_SAMPLE_Z;
            `CHK(mem_output_float, float_exp)
            len = codes[k] == `INS_BYPASS ? 2 : (codes[k] == `INS_IDCODE ? `ID_WIDTH : `BSR_LONG);
            exp_q.push_back(codes[k] == `INS_BYPASS ? {68'h0, din[0], 1'b0} :
                (codes[k] == `INS_IDCODE ? ID_EXP : ring()));
            scan_master_i.scan(1'b0, len, din);
            $display("test of instruction %h done", codes[k]);
        end
        scan_master_i.reset_tap();
        `CHK(mem_output_float, 1'b0)
        exp_q.push_back(ID_EXP);
        scan_master_i.scan(1'b0, `ID_WIDTH, din);
        $display("test of logic reset done");
        #1us;
        summarize();
    end
endmodule : test_sram_jtag_tap
